//--- overlay_wait_state_generator.sv
// Overlay memory wait-state generator: counts wait states, then returns ready.
// Assumes bus cycle start, overlay hit and target ready are on clk_i.
//
// Functional notes
// [R1] Programmable wait count 0..15; insert exactly that many waits before ready.
// [R2] Wait count zero returns ready with no wait states.
// [R3] Standard board above 12.5 MHz forces count to one; writes cannot override.
// [R4] Fast overlay board forces the wait count to zero.
// [R5] Generator acts only while internal-ready selection is on.
// [R6] Count and internal ready affect only overlay hits, never target memory.
// [R7] Waits are the larger of overlay count and chip-select wait count.
// [R8] Ignore-external-ready set: waits equal chip-select count 0..3, overlay ignored.
// [R9] At 16 MHz standard board, system programs count or target waits.
// [R10] Programmer should give at least one chip-select wait above 12.5 MHz.
// [R11] Fast board adds no overlay waits even at 16 MHz; only chip-select waits (0..3) remain.
// [R12] Internal ready makes the emulator supply its own ready on overlay access.
// [R13] Without internal ready, overlay cycles end on target ready; no own ready.
`timescale 1ns/1ps
module overlay_wait_state_generator
  import overlay_wait_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic count_write_i,
  input wire logic [COUNT_W-1:0] count_data_i,
  input wire logic [CLK_KHZ_W-1:0] target_clk_khz_i,
  input wire logic fast_board_i,
  input wire logic internal_ready_sel_i,
  input wire logic overlay_mapped_i,
  input wire logic cycle_start_i,
  input wire logic overlay_hit_i,
  input wire logic target_ready_i,
  input wire logic ignore_external_ready_bit_i,
  input wire logic chip_select_wait_bit_low_i,
  input wire logic chip_select_wait_bit_high_i,
  output logic [COUNT_W-1:0] overlay_wait_count_o,
  output logic ready_o,
  output logic ready_oe_o,
  output logic busy_o
);

  // ==========================================================
  // Wait count register
  logic [COUNT_W-1:0] programmed;
  logic [COUNT_W-1:0] next_programmed;
  logic [COUNT_W-1:0] overlay_wait_count;
  logic std_fast_clk;

  // Standard board limit compare on the frequency word
  assign std_fast_clk = (32'(target_clk_khz_i) > STD_BOARD_LIMIT_KHZ); // [R3]

  always_comb begin
    next_programmed = programmed;
    if (count_write_i) begin
      next_programmed = count_data_i; // [R1]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      programmed <= WAIT_RESET;
    end else if (clk_en_i) begin
      programmed <= next_programmed;
    end
  end

  // ==========================================================
  // Effective wait count after board and clock forcing
  // Forcing never touches the stored value, so it returns once lifted
  always_comb begin
    if (fast_board_i) begin
      overlay_wait_count = WAIT_NONE; // [R4] [R11]
    end else if (std_fast_clk) begin
      overlay_wait_count = WAIT_ONE; // [R3]
    end else begin
      overlay_wait_count = programmed; // [R1]
    end
  end

  // ==========================================================
  // Chip-select wait count, widened to the overlay count width
  logic [COUNT_W-1:0] cs_wait;
  logic [CS_WAIT_W-1:0] cs_bits;

  assign cs_bits = {chip_select_wait_bit_high_i, chip_select_wait_bit_low_i};

  for (genvar b = 0; b < COUNT_W; b++) begin : g_cs_bit
    if (b < CS_WAIT_W) begin : g_used
      assign cs_wait[b] = cs_bits[b];
    end else begin : g_pad
      assign cs_wait[b] = 1'b0;
    end
  end

  // ==========================================================
  // Number of wait states for the cycle being started
  logic [COUNT_W-1:0] wait_target;
  logic zero_wait;

  always_comb begin
    if (ignore_external_ready_bit_i) begin
      wait_target = cs_wait; // [R8]
    end else if (overlay_wait_count > cs_wait) begin
      wait_target = overlay_wait_count; // [R7]
    end else begin
      wait_target = cs_wait; // [R7]
    end
  end

  assign zero_wait = (wait_target == WAIT_NONE); // [R2]

  // ==========================================================
  // Bus cycle sequencer
  cycle_state_t state;
  cycle_state_t next_state;
  logic [COUNT_W-1:0] remain;
  logic [COUNT_W-1:0] next_remain;
  logic take;
  logic wait_done;

  // Generator only for overlay hits with internal ready selected
  assign take = cycle_start_i && overlay_hit_i && overlay_mapped_i
                && internal_ready_sel_i; // [R5] [R6] [R12]
  assign wait_done = (remain == WAIT_NONE); // [R1]

  always_comb begin
    next_state = state;
    next_remain = remain;
    case (state)
      ST_IDLE: begin
        if (take) begin
          if (zero_wait) begin
            next_state = ST_DONE; // [R2]
          end else begin
            next_remain = wait_target - WAIT_ONE; // [R1]
            next_state = ST_WAIT;
          end
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_WAIT: begin
        if (wait_done) begin
          next_state = ST_DONE;
        end else begin
          next_remain = remain - WAIT_ONE; // [R1]
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      remain <= WAIT_NONE;
    end else if (clk_en_i) begin
      state <= next_state;
      remain <= next_remain;
    end
  end

  // ==========================================================
  // Ready, ready enable and status outputs
  logic next_ready;
  logic next_oe;
  logic next_busy;
  logic [COUNT_W-1:0] next_count_o;

  always_comb begin
    next_ready = 1'b0;
    next_oe = 1'b0;
    next_busy = 1'b0;
    next_count_o = overlay_wait_count;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_busy = 1'b1;
          next_oe = 1'b1; // [R12]
          if (zero_wait) begin
            next_ready = 1'b1; // [R2]
          end
        end
      end
      ST_WAIT: begin
        next_busy = 1'b1;
        next_oe = 1'b1; // [R12]
        if (wait_done) begin
          next_ready = 1'b1; // [R1]
        end
      end
      ST_DONE: begin
        next_busy = 1'b0;
        next_oe = 1'b0; // [R13]
      end
      default: begin
        next_busy = 1'b0;
        next_oe = 1'b0; // [R13]
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b0;
      ready_oe_o <= 1'b0; // [R13]
      busy_o <= 1'b0;
      overlay_wait_count_o <= WAIT_RESET;
    end else if (clk_en_i) begin
      ready_o <= next_ready;
      ready_oe_o <= next_oe; // [R13]
      busy_o <= next_busy;
      overlay_wait_count_o <= next_count_o;
    end
  end

endmodule : overlay_wait_state_generator

//--- overlay_wait_pkg.sv
// Constants for the overlay memory wait-state generator.
// Assumes a single 20 MHz clock domain shared with the processor bus.
package overlay_wait_pkg;
  localparam int unsigned COUNT_W = 4;
  localparam int unsigned CS_WAIT_W = 2;
  localparam logic [COUNT_W-1:0] WAIT_NONE = 4'h0;
  localparam logic [COUNT_W-1:0] WAIT_ONE = 4'h1;
  localparam logic [COUNT_W-1:0] WAIT_RESET = 4'h0;
  // Above this clock the standard board needs one wait state
  localparam int unsigned STD_BOARD_LIMIT_KHZ = 12500;
  localparam int unsigned CLK_KHZ_W = 16;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_DONE
  } cycle_state_t;
endpackage : overlay_wait_pkg

//--- cpu_bus_model.sv
// Processor bus model: issues one bus cycle and waits for its ready
// Assumes the generator's ready, ready enable and the target ready as inputs
`timescale 1ns/1ps
module cpu_bus_model (
  input wire logic clk_i,
  input wire logic rdy_i,
  input wire logic oe_i,
  input wire logic trdy_i,
  output logic start_o = 1'b0,
  output logic hit_o = 1'b0
);
  // Hit line shows the inverse once the start has been sampled
  task automatic run(input logic h, output int k);
    @(posedge clk_i) #2 start_o = 1'b1;
    hit_o = h;
    @(posedge clk_i) #2 start_o = 1'b0;
    hit_o = ~h;
    for (k = 1; k < 40; k++) begin
      @(negedge clk_i);
      if (oe_i ? rdy_i : trdy_i) break;
    end
  endtask : run
endmodule : cpu_bus_model

//--- overlay_wait_state_generator_assertions.sv
// Checker of ready timing for the overlay wait-state generator
// Assumes a bind onto the generator's ports
`timescale 1ns/1ps
module ovw_chk
  import overlay_wait_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic cycle_start_i,
  input wire logic overlay_hit_i,
  input wire logic overlay_mapped_i,
  input wire logic internal_ready_sel_i,
  input wire logic ignore_external_ready_bit_i,
  input wire logic ready_o,
  input wire logic ready_oe_o,
  input wire logic chip_select_wait_bit_low_i,
  input wire logic chip_select_wait_bit_high_i,
  input wire logic busy_o,
  input wire logic [COUNT_W-1:0] overlay_wait_count_o
);
  logic [3:0] cs, n, nq;
  logic [4:0] c, st;
  logic take;
  assign cs = {2'b00, chip_select_wait_bit_high_i, chip_select_wait_bit_low_i};
  assign n = ignore_external_ready_bit_i || cs > overlay_wait_count_o ? cs : overlay_wait_count_o;
  assign take = clk_en_i && cycle_start_i && overlay_hit_i && overlay_mapped_i
    && internal_ready_sel_i && !busy_o;
  assign st = nq == 0 ? 5'd1 : 5'(nq) + 5'd1;
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) {c, nq} <= '0;
    else if (clk_en_i) {c, nq} <= {take ? 5'd1 : c + 5'(c != 0), take ? n : nq};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_TAKE: assert property (take |=> busy_o) else $error("no start");
  AST_LIMIT: assert property (busy_o |-> c inside {[1:16]}) else $error("long");
  AST_HOLD: assert property (clk_en_i && busy_o && !ready_o |=> busy_o) else $error("drop");
  AST_AT: assert property (ready_o |-> c == st) else $error("waits");
  AST_ZERO: assert property (take && n == 0 |=> ready_o) else $error("zero");
  AST_IDLE: assert property (!busy_o && !take |=> !(ready_oe_o || ready_o))
    else $error("own");
  AST_END: assert property (clk_en_i && ready_o |=> !busy_o) else $error("end");
  AST_OE: assert property (ready_oe_o == busy_o && (busy_o || !ready_o)) else $error("oe");
  cover property (take && n == 0);
  cover property (take && ignore_external_ready_bit_i);
  cover property (ready_o && nq == 15);
endmodule : ovw_chk
bind overlay_wait_state_generator ovw_chk ovw_chk_i (.*);

//--- test_overlay_wait_state_generator.sv
// Random bench for the overlay wait-state generator
// Assumes the bus model issues each cycle
`timescale 1ns/1ps
module test_overlay_wait_state_generator;
  import overlay_wait_pkg::*;
  logic clk_i = 0, rst_n_i = 0, clk_en_i = 1, target_ready_i = 1, count_write_i = 0, hit = 0;
  logic fast_board_i = 0, internal_ready_sel_i = 0, overlay_mapped_i = 0, cycle_start_i;
  logic ignore_external_ready_bit_i = 0, chip_select_wait_bit_low_i = 0, overlay_hit_i;
  logic chip_select_wait_bit_high_i = 0, ready_o, ready_oe_o, busy_o;
  logic [COUNT_W-1:0] count_data_i = 0, overlay_wait_count_o, prog = WAIT_RESET, eff, n;
  logic [CLK_KHZ_W-1:0] target_clk_khz_i = 0;
  int n_fail = 0, n_tests = 0, k;
  overlay_wait_state_generator overlay_wait_state_generator_i (.*);
  cpu_bus_model cpu_bus_model_i (.clk_i, .rdy_i(ready_o), .oe_i(ready_oe_o),
    .trdy_i(target_ready_i), .start_o(cycle_start_i), .hit_o(overlay_hit_i));
  function automatic logic [5:0] exp_k();
    n = {2'b00, chip_select_wait_bit_high_i, chip_select_wait_bit_low_i};
    if (!ignore_external_ready_bit_i && eff > n) n = eff;
    return internal_ready_sel_i && overlay_mapped_i && hit && n != 0 ? 6'(n) + 6'd1 : 6'd1;
  endfunction : exp_k
  task automatic check(input string s, input logic [5:0] g, e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %0d got %0d", s, e, g);
    end
  endtask : check
  task automatic summarize();
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  initial forever #25 clk_i = ~clk_i;
  initial begin
    void'($urandom(32'hbc03));
    repeat (4) @(posedge clk_i);
    #2 rst_n_i = 1;
    for (int i = 0; i < 150; i++) begin
      {hit, overlay_mapped_i, internal_ready_sel_i, count_write_i} = 4'($urandom | $urandom);
      {fast_board_i, ignore_external_ready_bit_i, chip_select_wait_bit_high_i,
        chip_select_wait_bit_low_i, count_data_i} = 8'($urandom);
      target_clk_khz_i = i < 2 ? 16'(12500 + i) : 16'($urandom_range(16000, 8000));
      if (!fast_board_i && target_clk_khz_i > STD_BOARD_LIMIT_KHZ) begin
        internal_ready_sel_i = 1'b1;
        if (ignore_external_ready_bit_i) chip_select_wait_bit_low_i = 1'b1;
      end
      if (count_write_i) prog = count_data_i;
      eff = fast_board_i ? WAIT_NONE : target_clk_khz_i > STD_BOARD_LIMIT_KHZ ? WAIT_ONE : prog;
      repeat (2) @(posedge clk_i);
      #2 count_write_i = 0;
      check("count", 6'(overlay_wait_count_o), 6'(eff));
      if (i % 8 == 0) begin
        clk_en_i = 0;
        @(posedge clk_i) #2 count_write_i = 1;
        count_data_i = ~prog;
        repeat (2) @(posedge clk_i);
        #2 check("freeze", 6'(overlay_wait_count_o), 6'(eff));
        count_write_i = 0;
        clk_en_i = 1;
      end
      cpu_bus_model_i.run(hit, k);
      check("waits", 6'(k), exp_k());
      if (k > 39) summarize();
      @(posedge clk_i) #2;
    end
    summarize();
  end
endmodule : test_overlay_wait_state_generator
